/* File: include/emp_pkg.sv */
// package for the external mii and management port
package emp_pkg;

  localparam int          NIB_W        = 4;
  localparam int          SYNC_STAGES  = 2;
  localparam logic [3:0]  TXD_RST      = 4'h0;
  localparam logic        BIT_RST      = 1'h0;
  // mdc divider: half period in sys_clk cycles
  localparam int          MDC_HALF_CYC = 2;
  localparam logic [7:0]  MDC_CNT_RST  = 8'h00;

  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       crs;
    logic       col;
  } emp_rx_pins_t;

  typedef struct packed {
    logic [3:0] data;
    logic       valid;
  } emp_nib_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RECV = 3'b010,
    ST_DONE = 3'b100
  } emp_rx_st_t;

endpackage

/* File: src/emp_port.sv */
// external mii data path and management pin control
//
// Summary of operation
// R1 - phy supplies 25 or 2.5 MHz clocks; the bench phy model supplies 1.25 MHz (800 ns period)
// R2 - internal phy selected: txd held zero
// R3 - internal phy selected: tx_en held zero
// R4 - tx_en only with a valid nibble
// R5 - phy delivers four bit receive nibbles
// R6 - rxd used only while rx_dv high
// R7 - rx_er during frame flags frame errored
// R8 - phy raises col on collision
// R9 - phy raises crs on carrier
// R10 - select one: mdio and mdc active
// R11 - select zero: mdio released, mdc low
// R12 - mdio sampled as external phy strap
// R13 - tx launched, rx sampled on phy clocks
`timescale 1ns/10ps
`default_nettype none

module emp_port
  import emp_pkg::*;
(
  // system
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // configuration
  input  wire logic             ext_phy_sel,
  input  wire logic             mgmt_port_select,
  output var  logic             external_phy_present_strap,
  // mac transmit side
  input  wire logic [3:0]       mac_txd,
  input  wire logic             mac_tx_valid,
  output var  logic             mac_tx_take,
  // mac receive side
  output var  emp_nib_t         mac_rx,
  output var  logic             mac_rx_end,
  output var  logic             mac_rx_err,
  output var  logic             mac_crs,
  output var  logic             mac_col,
  // mac management side
  input  wire logic             mac_mdo,
  input  wire logic             mac_mdo_en,
  output var  logic             mac_mdi,
  // mii pins
  input  wire logic             tx_clk,
  output var  logic [3:0]       txd,
  output var  logic             tx_en,
  input  wire logic             rx_clk,
  input  wire emp_rx_pins_t     rx_pins,
  // management pins
  input  wire logic             mdio_i,
  output var  logic             mdio_o,
  output var  logic             mdio_oe,
  output var  logic             mdc
);

  typedef struct packed {
    logic [2:0]   txc_s;
    logic [2:0]   rxc_s;
    logic [1:0]   mdio_s;
    emp_rx_pins_t rx_s1;
    emp_rx_pins_t rx_s2;
    logic         strap_done;
    logic         strap;
    emp_rx_st_t   st;
    logic         err;
    logic [3:0]   txd;
    logic         tx_en;
    logic         take;
    emp_nib_t     rx;
    logic         rx_end;
    logic         rx_err;
    logic         crs;
    logic         col;
    logic [7:0]   mdc_cnt;
    logic         mdc;
    logic         mdio_o;
    logic         mdio_oe;
    logic         mdi;
  } emp_state_t;

  emp_state_t s_q;
  emp_state_t s_d;

  // edges judged on stages two and three; stage one may be metastable
  function automatic logic rise(input logic [2:0] sync);
    return sync[1] & ~sync[2];
  endfunction

  function automatic logic fall(input logic [2:0] sync);
    return sync[2] & ~sync[1];
  endfunction

  logic tx_fall;
  logic rx_rise;
  assign tx_fall = fall(s_q.txc_s);
  assign rx_rise = rise(s_q.rxc_s);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.txc_s  = {s_q.txc_s[1:0], tx_clk};
    s_d.rxc_s  = {s_q.rxc_s[1:0], rx_clk};
    s_d.mdio_s = {s_q.mdio_s[0], mdio_i};
    // pins are sampled twice before anything reads them
    s_d.rx_s1  = rx_pins;
    s_d.rx_s2  = s_q.rx_s1;
    s_d.take   = 1'b0;
    s_d.rx_end = 1'b0;
    s_d.rx.valid = 1'b0;

    // strap caught once after reset release
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.strap      = s_q.mdio_s[1];               // [R12]
    end

    // launch on falling tx_clk so phy samples stable data on rising
    if (!ext_phy_sel) begin
      s_d.txd   = TXD_RST;                          // [R2]
      s_d.tx_en = BIT_RST;                          // [R3]
    end else if (tx_fall) begin                     // [R13]
      s_d.txd   = mac_tx_valid ? mac_txd : TXD_RST;
      s_d.tx_en = mac_tx_valid;                     // [R4]
      s_d.take  = mac_tx_valid;
    end

    // crs and col pass as levels, already synchronised
    s_d.crs = s_q.rx_s2.crs;
    s_d.col = s_q.rx_s2.col;

    if (rx_rise) begin                              // [R13]
      case (s_q.st)
        ST_IDLE: begin
          s_d.err = 1'b0;
          if (s_q.rx_s2.rx_dv) begin
            s_d.st  = ST_RECV;
            s_d.rx  = '{data: s_q.rx_s2.rxd, valid: 1'b1}; // [R6]
            s_d.err = s_q.rx_s2.rx_er;              // [R7]
          end
        end
        ST_RECV: begin
          if (s_q.rx_s2.rx_dv) begin
            s_d.rx  = '{data: s_q.rx_s2.rxd, valid: 1'b1}; // [R6]
            s_d.err = s_q.err | s_q.rx_s2.rx_er;    // [R7]
          end else begin
            s_d.st = ST_DONE;
          end
        end
        ST_DONE: begin
          s_d.st = ST_IDLE;
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
    // frame end flagged with its error status
    if (rx_rise && s_q.st == ST_RECV && !s_q.rx_s2.rx_dv) begin
      s_d.rx_end = 1'b1;
      s_d.rx_err = s_q.err;                         // [R7]
    end

    // management port: divider makes mdc from sys_clk
    if (mgmt_port_select) begin                     // [R10]
      if (s_q.mdc_cnt == 8'(MDC_HALF_CYC - 1)) begin
        s_d.mdc_cnt = MDC_CNT_RST;
        s_d.mdc     = ~s_q.mdc;
      end else begin
        s_d.mdc_cnt = s_q.mdc_cnt + 8'h01;
      end
      s_d.mdio_o  = mac_mdo;
      s_d.mdio_oe = mac_mdo_en;
      s_d.mdi     = s_q.mdio_s[1];
    end else begin
      s_d.mdc_cnt = MDC_CNT_RST;
      s_d.mdc     = BIT_RST;                        // [R11]
      s_d.mdio_o  = BIT_RST;
      s_d.mdio_oe = BIT_RST;                        // [R11]
      s_d.mdi     = BIT_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q        <= '0;
      s_q.st     <= ST_IDLE;
      // synchronisers run on: strap valid and no false edge at release
      s_q.txc_s  <= s_d.txc_s;
      s_q.rxc_s  <= s_d.rxc_s;
      s_q.mdio_s <= s_d.mdio_s;
    end else begin
      s_q <= s_d;
    end
  end

  assign external_phy_present_strap = s_q.strap;
  assign mac_tx_take = s_q.take;
  assign mac_rx      = s_q.rx;
  assign mac_rx_end  = s_q.rx_end;
  assign mac_rx_err  = s_q.rx_err;
  assign mac_crs     = s_q.crs;
  assign mac_col     = s_q.col;
  assign mac_mdi     = s_q.mdi;
  assign txd         = s_q.txd;
  assign tx_en       = s_q.tx_en;
  assign mdio_o      = s_q.mdio_o;
  assign mdio_oe     = s_q.mdio_oe;
  assign mdc         = s_q.mdc;

  ////////////////////////////////////////////////////////////////////////
  property p_int_txd;
    @(posedge sys_clk) disable iff (!nrst)
      !ext_phy_sel |=> txd == 4'h0;
  endproperty
  a_int_txd: assert property (p_int_txd) else $error("txd not parked"); // [R2]

  property p_int_txen;
    @(posedge sys_clk) disable iff (!nrst)
      !ext_phy_sel |=> !tx_en;
  endproperty
  a_int_txen: assert property (p_int_txen) else $error("tx_en not low"); // [R3]

  property p_txen_data;
    @(posedge sys_clk) disable iff (!nrst)
      ext_phy_sel && tx_fall && mac_tx_valid |=> tx_en && txd == $past(mac_txd);
  endproperty
  a_txen_data: assert property (p_txen_data) else $error("tx nibble lost"); // [R4]

  property p_txen_idle;
    @(posedge sys_clk) disable iff (!nrst)
      tx_en |-> mac_tx_take || $stable(tx_en);
  endproperty
  a_txen_idle: assert property (p_txen_idle) else $error("tx_en moved"); // [R13]

  property p_rx_valid;
    @(posedge sys_clk) disable iff (!nrst)
      mac_rx.valid |-> $past(s_q.rx_s2.rx_dv) && $past(rx_rise);
  endproperty
  a_rx_valid: assert property (p_rx_valid) else $error("rx without dv"); // [R6]

  property p_rx_err;
    @(posedge sys_clk) disable iff (!nrst)
      s_q.st == ST_RECV && rx_rise && s_q.rx_s2.rx_er && s_q.rx_s2.rx_dv
      |=> s_q.err;
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("error missed"); // [R7]

  property p_mdc_off;
    @(posedge sys_clk) disable iff (!nrst)
      !mgmt_port_select |=> !mdc && !mdio_oe;
  endproperty
  a_mdc_off: assert property (p_mdc_off) else $error("mgmt not parked"); // [R11]

  property p_mdc_on;
    @(posedge sys_clk) disable iff (!nrst)
      mgmt_port_select [*4] |-> $changed(mdc) or $past(mdc) != $past(mdc, 2);
  endproperty
  a_mdc_on: assert property (p_mdc_on) else $error("mdc stuck"); // [R10]

  property p_strap;
    @(posedge sys_clk) disable iff (!nrst)
      $rose(s_q.strap_done) |-> external_phy_present_strap == $past(s_q.mdio_s[1]);
  endproperty
  a_strap: assert property (p_strap) else $error("strap wrong"); // [R12]

  c_rx_frame: cover property (@(posedge sys_clk) disable iff (!nrst) mac_rx_end);
  c_rx_err:   cover property (@(posedge sys_clk) disable iff (!nrst)
                mac_rx_end && mac_rx_err);
  c_tx:       cover property (@(posedge sys_clk) disable iff (!nrst) tx_en);

endmodule

`default_nettype wire

/* File: tb/emp_phy_model.sv */
// behavioural external phy facing the mii pins
`timescale 1ns/10ps
`default_nettype none

module emp_phy_model
  import emp_pkg::*;
(
  // phy clocks
  output var logic         tx_clk,
  output var logic         rx_clk,
  // receive pins
  output var emp_rx_pins_t rx_pins
);
  logic [3:0] last = 4'h5;

  // mii clocks run free; odd offsets keep them off the system edges
  initial begin
    tx_clk = 1'b0;
    #271;
    forever #400 tx_clk = ~tx_clk;
  end
  initial begin
    rx_clk = 1'b0;
    rx_pins = '0;
    #133;
    forever #400 rx_clk = ~rx_clk;
  end

  // one nibble, launched on the falling edge for the next rise
  task automatic nib(input logic [3:0] d, input logic e, input logic c);
    @(negedge rx_clk);
    rx_pins <= '{d, 1'b1, e, 1'b1, c};
    last = d;
  endtask

  // rxd3..1 fall to their pull-downs; rxd0 has none, so it shows a flip
  task automatic idle();
    @(negedge rx_clk);
    rx_pins <= '{{3'b000, ~last[0]}, 1'b0, 1'b0, 1'b0, 1'b0};
  endtask
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the external mii port
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import emp_pkg::*;
  logic         sys_clk = 1'b0;
  logic         nrst = 1'b0;
  logic         ext_phy_sel = 1'b0;
  logic         mgmt_port_select = 1'b0;
  logic         strap = 1'b1;
  logic [3:0]   mac_txd = 4'h0;
  logic         mac_tx_valid = 1'b0;
  logic         mac_mdo = 1'b0;
  logic         mac_mdo_en = 1'b0;
  logic         external_phy_present_strap, mac_tx_take, mac_rx_end;
  logic         mac_rx_err, mac_crs, mac_col, mac_mdi;
  logic         tx_clk, rx_clk, tx_en, mdio_o, mdio_oe, mdc;
  logic [3:0]   txd;
  emp_nib_t     mac_rx;
  emp_rx_pins_t rx_pins;
  wire logic    mdio_i;
  int           bad_count = 0, checks = 0, cyc = 0;
  logic [3:0]   txq[$], rxq[$];
  logic         exp_err = 1'b0, saw_col = 1'b0, saw_crs = 1'b0;
  logic [7:0]   hi;

  // released mdio falls to the strap level set on the board
  assign mdio_i = (mdio_oe === 1'b1) ? mdio_o : strap;
  always #50 sys_clk = ~sys_clk;

  emp_port uut (.sys_clk, .nrst, .ext_phy_sel, .mgmt_port_select,
    .external_phy_present_strap, .mac_txd, .mac_tx_valid, .mac_tx_take,
    .mac_rx, .mac_rx_end, .mac_rx_err, .mac_crs, .mac_col, .mac_mdo,
    .mac_mdo_en, .mac_mdi, .tx_clk, .txd, .tx_en, .rx_clk, .rx_pins,
    .mdio_i, .mdio_o, .mdio_oe, .mdc);
  emp_phy_model u_phy (.tx_clk, .rx_clk, .rx_pins);

  task automatic chk(string n, logic [3:0] s, logic [3:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic do_reset(logic s);
    @(posedge sys_clk);
    strap <= s;
    nrst <= 1'b0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic quiet_tx();
    repeat (24) begin
      @(posedge sys_clk);
      chk("txd", txd, 4'h0);
      chk("tx_en", tx_en, 4'h0);
    end
  endtask

  task automatic send_tx(int n);
    logic [3:0] d;
    repeat (n) begin
      @(posedge sys_clk);
      d = 4'($urandom);
      mac_txd <= d;
      mac_tx_valid <= 1'b1;
      txq.push_back(d);
      for (int i = 0; i < 40 && mac_tx_take !== 1'b1; i++)
        @(posedge sys_clk);
    end
    @(posedge sys_clk);
    mac_tx_valid <= 1'b0;
  endtask

  task automatic rx_frame(int n, logic e, logic c);
    logic [3:0] d;
    exp_err = e;
    for (int i = 0; i < n; i++) begin
      d = 4'($urandom);
      rxq.push_back(d);
      u_phy.nib(d, e && i == n / 2, c && i == 1);
    end
    u_phy.idle();
    repeat (40) @(posedge sys_clk);
    chk("rx_left", 4'(rxq.size()), 4'h0);
    chk("crs_idle", mac_crs, 4'h0);
  endtask

  // results are matched against the oldest note as they appear
  // ceiling far above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  always @(posedge sys_clk) begin
    if (mac_tx_take === 1'b1) begin
      chk("txd", txd, txq.size() ? txq.pop_front() : 4'hX);
      chk("tx_en", tx_en, 4'h1);
    end
    if (mac_rx.valid === 1'b1)
      chk("rxd", mac_rx.data, rxq.size() ? rxq.pop_front() : 4'hX);
    if (mac_rx_end === 1'b1)
      chk("rx_err", mac_rx_err, exp_err);
    if (mac_col === 1'b1)
      saw_col <= 1'b1;
    if (mac_crs === 1'b1)
      saw_crs <= 1'b1;
  end

  initial begin
    void'($urandom(41453));
    do_reset(1'b1);
    chk("strap", external_phy_present_strap, 4'h1);
    do_reset(1'b0);
    chk("strap", external_phy_present_strap, 4'h0);
    $display("test strap done");
    mac_tx_valid <= 1'b1;
    quiet_tx();
    ext_phy_sel <= 1'b1;
    mac_tx_valid <= 1'b0;
    send_tx(12);
    // last nibble stands until the next tx_clk fall
    repeat (10) @(posedge sys_clk);
    quiet_tx();
    $display("test transmit done");
    rx_frame(6, 1'b0, 1'b0);
    rx_frame(9, 1'b1, 1'b0);
    chk("col_early", saw_col, 4'h0);
    rx_frame(5, 1'b0, 1'b1);
    chk("col", saw_col, 4'h1);
    chk("crs", saw_crs, 4'h1);
    $display("test receive done");
    mgmt_port_select <= 1'b1;
    mac_mdo_en <= 1'b1;
    mac_mdo <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("mdio_oe", mdio_oe, 4'h1);
    chk("mdi", mac_mdi, 4'h1);
    hi = 8'h00;
    repeat (40) begin
      @(posedge sys_clk);
      hi = hi + {7'h00, mdc};
    end
    chk("mdc_hi", hi[3:0], 4'h4);
    chk("mdc_hi_top", hi[7:4], 4'h1);
    mac_mdo_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("mdio_oe_off", mdio_oe, 4'h0);
    mgmt_port_select <= 1'b0;
    repeat (4) @(posedge sys_clk);
    repeat (20) begin
      @(posedge sys_clk);
      chk("mdc", mdc, 4'h0);
      chk("mdio_oe", mdio_oe, 4'h0);
      chk("mdi", mac_mdi, 4'h0);
    end
    $display("test management done");
    wrap_up();
  end
endmodule

`default_nettype wire
